//--- verilog/line_event_pkg.sv
// constants shared by the line event capture logic
`default_nettype none
package line_event_pkg;
  localparam int         REG_W          = 8;
  localparam int         ADDR_W         = 6;
  localparam int         SRC_N          = 5;
  localparam int         RSV_W          = REG_W - SRC_N;
  // register offset of line_event_capture
  localparam logic [5:0] CAPTURE_OFFSET = 6'h14;
  // bit positions inside line_event_capture
  localparam int         BIT_HOST_DISC  = 0;
  localparam int         BIT_BUS_VOLT   = 1;
  localparam int         BIT_SESS_VALID = 2;
  localparam int         BIT_SESS_END   = 3;
  localparam int         BIT_ID_GROUND  = 4;
  localparam logic [7:0] CAPTURE_RESET  = 8'h00;
  localparam logic [2:0] RESERVED_READ  = 3'h0;
  localparam logic [4:0] SRC_NONE       = 5'h00;
  typedef enum logic {ST_INIT, ST_RUN} latch_state_t;
endpackage
`default_nettype wire

//--- verilog/line_event_if.sv
// per-source signal bundle between capture control and one event bit
`default_nettype none
interface line_event_if;
  logic status;
  logic rise_en;
  logic fall_en;
  logic gate;
  logic load;
  logic clear_read;
  logic clear_mode;
  logic hit;
  logic latch;
  modport bit_end (
    input  status, rise_en, fall_en, gate, load, clear_read, clear_mode,
    output hit, latch
  );
  modport ctrl_end (
    output status, rise_en, fall_en, gate, load, clear_read, clear_mode,
    input  hit, latch
  );
endinterface
`default_nettype wire

//--- verilog/line_event_bit.sv
// one change detector and sticky capture bit
`default_nettype none
module line_event_bit #(
  parameter bit INIT_FROM_STATUS = 1'b0
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset_n,
  // bundle from the control side
  line_event_if.bit_end   bi
);
  logic prev;
  logic latch;
  logic next_latch;
  wire  rose = bi.status & ~prev;
  wire  fell = ~bi.status & prev;

  // edge qualified by the matching enable
  assign bi.hit   = bi.gate & ((rose & bi.rise_en) | (fell & bi.fall_en));
  assign bi.latch = latch;

  // read clear beats a set: the read data already carries the event
  always_comb begin
    next_latch = latch;
    if (bi.load) begin
      next_latch = INIT_FROM_STATUS ? bi.status : 1'b0;
    end else if (bi.clear_read) begin
      next_latch = 1'b0;
    end else if (bi.hit) begin
      next_latch = 1'b1;
    end else if (bi.clear_mode) begin
      next_latch = 1'b0;
    end
  end

  // previous sample and capture flop
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev  <= 1'b0;
      latch <= 1'b0;
    end else begin
      prev  <= bi.status;
      latch <= next_latch;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  chk_hit_sets_bit: assert property (bi.hit && !bi.clear_read && !bi.load |=> latch)
    else $error("unmasked change did not set capture bit");
  chk_masked_stays_clear: assert property (
    !bi.hit && !bi.load && !latch |=> !latch)
    else $error("capture bit set without qualified change");
  chk_read_clears_bit: assert property (bi.clear_read && !bi.load |=> !latch)
    else $error("read did not leave capture bit clear");
endmodule
`default_nettype wire

//--- verilog/phy_line_event_latch.sv
// read-to-clear capture register for line and session status changes
`default_nettype none
// Functional notes
// - a qualified change on any status source sets its capture bit
// - reading the capture register clears every bit
// - entering low power mode clears every bit that has no coinciding event
// - entering serial or car-kit mode clears all bits without a coinciding event, clock suspend ignored
// - event coinciding with a read appears in read data, bit stays clear
// - bit 4 captures id ground changes, read clears it
// - bit 3 captures session end changes, read clears it
// - bit 2 captures session valid (same as A-device valid) changes
// - bit 1 captures bus voltage valid changes, read clears it
// - bit 0 captures host disconnect changes, only in host mode
// - bit 0 comes out of reset equal to host disconnect status
module phy_line_event_latch
  import line_event_pkg::*;
(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset_n,
  // internal status sources
  input  wire logic              i_id_ground_signal,
  input  wire logic              i_session_end_signal,
  input  wire logic              i_a_device_valid_signal,
  input  wire logic              i_bus_voltage_valid_signal,
  input  wire logic              i_host_disconnect_signal,
  // edge enables held by the enable registers
  input  wire logic [SRC_N-1:0]  i_rise_enable,
  input  wire logic [SRC_N-1:0]  i_fall_enable,
  // operating modes
  input  wire logic              i_host_mode,
  input  wire logic              i_low_power_mode,
  input  wire logic              i_serial_mode,
  input  wire logic              i_carkit_mode,
  input  wire logic              i_clock_suspend_control,
  // register read port
  input  wire logic              i_reg_read,
  input  wire logic [ADDR_W-1:0] i_reg_addr,
  output logic                   o_reg_valid,
  output logic      [REG_W-1:0]  o_reg_data,
  // current capture contents
  output logic      [REG_W-1:0]  o_capture
);
  latch_state_t     state;
  latch_state_t     next_state;
  logic             low_power_prev;
  logic             serial_prev;
  logic             carkit_prev;
  logic             reg_valid;
  logic [REG_W-1:0] reg_data;
  logic [SRC_N-1:0] status_vec;
  logic [SRC_N-1:0] hits;
  logic [SRC_N-1:0] latches;
  logic [SRC_N-1:0] gates;

  // status sources placed at their bit positions
  assign status_vec[BIT_ID_GROUND]  = i_id_ground_signal;
  assign status_vec[BIT_SESS_END]   = i_session_end_signal;
  assign status_vec[BIT_SESS_VALID] = i_a_device_valid_signal;
  assign status_vec[BIT_BUS_VOLT]   = i_bus_voltage_valid_signal;
  assign status_vec[BIT_HOST_DISC]  = i_host_disconnect_signal;

  // host disconnect only counts in host mode
  assign gates[BIT_ID_GROUND]  = (state == ST_RUN);
  assign gates[BIT_SESS_END]   = (state == ST_RUN);
  assign gates[BIT_SESS_VALID] = (state == ST_RUN);
  assign gates[BIT_BUS_VOLT]   = (state == ST_RUN);
  assign gates[BIT_HOST_DISC]  = (state == ST_RUN) & i_host_mode;

  // read decode; any other offset is left to its own register
  wire read_hit  = i_reg_read & (i_reg_addr == CAPTURE_OFFSET);
  wire load_all  = (state == ST_INIT);
  // mode entries are rising edges of the mode levels
  wire lp_entry  = i_low_power_mode & ~low_power_prev;
  wire ser_entry = i_serial_mode & ~serial_prev;
  wire car_entry = i_carkit_mode & ~carkit_prev;
  // clock suspend setting deliberately plays no part in the clear
  wire mode_clr  = lp_entry | ser_entry | car_entry;
  // a coinciding event goes straight into the read data
  wire [REG_W-1:0] read_word = {RESERVED_READ, latches | hits};

  // one detector per source, bit 0 seeded from host status
  for (genvar g = 0; g < SRC_N; g++) begin : g_src
    line_event_if ev ();
    assign ev.status     = status_vec[g];
    assign ev.rise_en    = i_rise_enable[g];
    assign ev.fall_en    = i_fall_enable[g];
    assign ev.gate       = gates[g];
    assign ev.load       = load_all;
    assign ev.clear_read = read_hit;
    assign ev.clear_mode = mode_clr;
    assign hits[g]       = ev.hit;
    assign latches[g]    = ev.latch;
    line_event_bit #(
      .INIT_FROM_STATUS (g == BIT_HOST_DISC)
    ) u_bit (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .bi        (ev.bit_end)
    );
  end

  // one settling cycle after reset seeds samples, so no false edge
  always_comb begin
    next_state = state;
    unique case (state)
      ST_INIT: next_state = ST_RUN;
      ST_RUN:  next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // previous mode levels for entry detection
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_power_prev <= 1'b0;
      serial_prev    <= 1'b0;
      carkit_prev    <= 1'b0;
    end else begin
      low_power_prev <= i_low_power_mode;
      serial_prev    <= i_serial_mode;
      carkit_prev    <= i_carkit_mode;
    end
  end

  // read answer, one cycle after the strobe; data held between reads
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reg_valid <= 1'b0;
      reg_data  <= CAPTURE_RESET;
    end else begin
      reg_valid <= read_hit;
      if (read_hit) begin
        reg_data <= read_word;
      end
    end
  end

  assign o_reg_valid = reg_valid;
  assign o_reg_data  = reg_data;
  assign o_capture   = {RESERVED_READ, latches};

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  // read side: clear, answer timing and what the answer carries
  chk_read_clears_all: assert property (
    read_hit && state == ST_RUN |=> latches == SRC_NONE)
    else $error("capture bits survived a read");

  // answer one cycle after the strobe, exactly the word formed then
  chk_read_shows_event: assert property (
    read_hit |=> o_reg_valid && o_reg_data == $past(read_word))
    else $error("read data lost a coinciding event");

  chk_event_in_data: assert property (
    read_hit && hits != SRC_NONE |=> (o_reg_data[SRC_N-1:0] & $past(hits)) == $past(hits)
  )
    else $error("coinciding event missing from read data");

  // no answer for any other offset or an idle port
  chk_answer_only_hit: assert property (!read_hit |=> !o_reg_valid)
    else $error("answer without a read of the capture offset");

  // unused upper bits never leak into either view
  chk_reserved_zero: assert property (
    o_reg_data[REG_W-1:SRC_N] == RESERVED_READ
    && o_capture[REG_W-1:SRC_N] == RESERVED_READ)
    else $error("reserved bits not zero");

  // data is held between answers; a link that samples late still sees it
  chk_data_held: assert property (
    !read_hit |=> $stable(o_reg_data))
    else $error("read data changed without a read");

  // a strobe at another offset belongs to another register
  chk_other_offset_keeps: assert property (
    i_reg_read && !read_hit && !mode_clr && hits == SRC_NONE && state == ST_RUN
    |=> latches == $past(latches))
    else $error("read of another offset disturbed capture bits");

  // mode entries wipe the register; only a coinciding event survives
  chk_low_power_clear: assert property (
    lp_entry && hits == SRC_NONE && state == ST_RUN |=> latches == SRC_NONE)
    else $error("low power entry left bits set");

  chk_serial_clear: assert property (
    (ser_entry || car_entry) && hits == SRC_NONE && state == ST_RUN
    |=> latches == SRC_NONE)
    else $error("serial or car-kit entry left bits set");

  // clock suspend must not hold back the serial or car-kit clear
  chk_suspend_ignored: assert property (
    (ser_entry || car_entry) && i_clock_suspend_control && hits == SRC_NONE
    && state == ST_RUN |=> latches == SRC_NONE)
    else $error("clear held back by clock suspend");

  chk_set_beats_mode: assert property (
    mode_clr && !read_hit && hits != SRC_NONE |=> (latches & $past(hits)) == $past(hits)
  )
    else $error("event lost to a mode clear");

  // event capture per source
  chk_host_gate: assert property (!i_host_mode |-> !hits[BIT_HOST_DISC])
    else $error("host disconnect event outside host mode");

  chk_reset_seed: assert property (
    state == ST_INIT |=> latches[BIT_HOST_DISC] == $past(i_host_disconnect_signal)
    && latches[SRC_N-1:1] == SRC_NONE[SRC_N-1:1])
    else $error("capture seed after reset wrong");

  // no detection while the previous samples are being seeded
  chk_init_quiet: assert property (state == ST_INIT |-> hits == SRC_NONE)
    else $error("event detected during the seeding cycle");

  chk_id_ground_set: assert property (
    hits[BIT_ID_GROUND] && !read_hit |=> latches[BIT_ID_GROUND])
    else $error("id ground event not captured");

  chk_sess_end_set: assert property (
    hits[BIT_SESS_END] && !read_hit |=> latches[BIT_SESS_END])
    else $error("session end event not captured");

  chk_sess_valid_set: assert property (
    hits[BIT_SESS_VALID] && !read_hit |=> latches[BIT_SESS_VALID])
    else $error("session valid event not captured");

  chk_bus_volt_set: assert property (
    hits[BIT_BUS_VOLT] && !read_hit |=> latches[BIT_BUS_VOLT])
    else $error("bus voltage event not captured");

  chk_host_disc_set: assert property (
    hits[BIT_HOST_DISC] && !read_hit |=> latches[BIT_HOST_DISC])
    else $error("host disconnect event not captured");

  // a bit moves only for a read, a mode entry or its own event
  chk_sticky_hold: assert property (
    state == ST_RUN && !read_hit && !mode_clr && hits == SRC_NONE
    |=> latches == $past(latches))
    else $error("capture bits changed with nothing to change them");

  // a newly set bit always traces back to a qualified change
  chk_set_needs_event: assert property (
    state == ST_RUN |=> (latches & ~$past(latches) & ~$past(hits)) == SRC_NONE)
    else $error("capture bit set without a qualified change");

  chk_rise_detect: assert property (
    state == ST_RUN && i_rise_enable[BIT_ID_GROUND] && $rose(i_id_ground_signal)
    |-> hits[BIT_ID_GROUND])
    else $error("enabled rise not detected");

  chk_fall_masked: assert property (
    !i_fall_enable[BIT_SESS_END] && $fell(i_session_end_signal)
    |-> !hits[BIT_SESS_END])
    else $error("masked fall produced an event");

  // per source checks; $rose and $fell see the sample the detector keeps
  // as its previous value, so they give an independent view of each edge
  for (genvar k = 0; k < SRC_N; k++) begin : g_chk
    chk_rise_seen: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      gates[k] && i_rise_enable[k] && $rose(status_vec[k]) |-> hits[k])
      else $error("enabled rise missed");

    chk_fall_seen: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      gates[k] && i_fall_enable[k] && $fell(status_vec[k]) |-> hits[k])
      else $error("enabled fall missed");

    chk_quiet_unqualified: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !(i_rise_enable[k] && $rose(status_vec[k]))
      && !(i_fall_enable[k] && $fell(status_vec[k])) |-> !hits[k])
      else $error("event without an enabled change");

    chk_event_reaches_data: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      read_hit && hits[k] |=> o_reg_data[k] && !latches[k])
      else $error("coinciding event not in data or bit left set");

    chk_mode_wipes_bit: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      mode_clr && !hits[k] && state == ST_RUN |=> !latches[k])
      else $error("mode entry left a quiet bit set");
  end

  // main scenarios: collision read, plain read, suspend ignored,
  // mode wipe and a seed taken with the host connected
  cov_seed_connected: cover property (state == ST_INIT && !i_host_disconnect_signal);
  cov_read_with_event: cover property (read_hit && hits != SRC_NONE);
  cov_read_nonzero: cover property (read_hit && latches != SRC_NONE);
  cov_suspend_serial: cover property (ser_entry && i_clock_suspend_control);
  cov_lp_clear: cover property (lp_entry && latches != SRC_NONE);
endmodule
`default_nettype wire

//--- bench/link_reader.sv
// link side model: issues register reads and keeps the answer
`default_nettype none
module link_reader
  import line_event_pkg::*;
(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset_n,
  // request and answer
  input  wire logic              i_start,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_reg_valid,
  input  wire logic [REG_W-1:0]  i_reg_data,
  // toward the block and the bench
  output logic                   o_reg_read,
  output logic      [ADDR_W-1:0] o_reg_addr,
  output logic                   o_got,
  output logic      [REG_W-1:0]  o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle address is inverted so a stale value is never mistaken for a request
  assign o_reg_read = i_start;
  assign o_reg_addr = i_start ? i_addr : ~i_addr;
  // answer taken at the edge where it stands
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_got  <= 1'b0;
      o_data <= 8'h00;
    end else begin
      o_got <= i_reg_valid;
      if (i_reg_valid) begin
        o_data <= i_reg_data;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the line event capture register
`default_nettype none
module testbench
  import line_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              i_ref_clk = 1'b0;
  logic              i_reset_n = 1'b0;
  logic [4:0]        src       = 5'h09; // bit 3 high so its masked fall is exercised
  logic [4:0]        rise_en   = 5'h1F;
  logic [4:0]        fall_en   = 5'h00;
  logic              host      = 1'b1;
  logic [2:0]        mode      = 3'h0;
  logic              susp      = 1'b0;
  logic              start     = 1'b0;
  logic [ADDR_W-1:0] addr      = CAPTURE_OFFSET;
  logic              rd;
  logic              valid;
  logic              got;
  logic [ADDR_W-1:0] rd_addr;
  logic [REG_W-1:0]  rdata;
  logic [REG_W-1:0]  cap;
  logic [REG_W-1:0]  got_data;
  int                n_errors    = 0;
  int                checks_done = 0;
  int                cycles      = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  phy_line_event_latch u_phy_line_event_latch (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_id_ground_signal(src[4]), .i_session_end_signal(src[3]),
    .i_a_device_valid_signal(src[2]), .i_bus_voltage_valid_signal(src[1]),
    .i_host_disconnect_signal(src[0]),
    .i_rise_enable(rise_en), .i_fall_enable(fall_en), .i_host_mode(host),
    .i_low_power_mode(mode[0]), .i_serial_mode(mode[1]), .i_carkit_mode(mode[2]),
    .i_clock_suspend_control(susp), .i_reg_read(rd), .i_reg_addr(rd_addr),
    .o_reg_valid(valid), .o_reg_data(rdata), .o_capture(cap));

  link_reader u_link_reader (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_start(start), .i_addr(addr),
    .i_reg_valid(valid), .i_reg_data(rdata), .o_reg_read(rd), .o_reg_addr(rd_addr),
    .o_got(got), .o_data(got_data));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one rising edge, then let its updates land
  task automatic step();
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic drive(input logic [4:0] s);
    @(negedge i_ref_clk);
    src = s;
    step();
  endtask

  // status may change in the strobe cycle to hit the read/set collision
  task automatic rd_check(input logic [5:0] a, input logic [4:0] s, input logic [7:0] ed,
                          input logic eg, input logic [7:0] ec);
    @(negedge i_ref_clk);
    start = 1'b1;
    addr  = a;
    src   = s;
    @(negedge i_ref_clk);
    start = 1'b0;
    step();
    check({7'h00, got}, {7'h00, eg});
    if (eg) check(got_data, ed);
    check(cap, ec);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard, the sequence needs well under 200 cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles > 600) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    logic [7:0] exp;
    repeat (12) @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    step();
    check(cap, 8'h01);
    rd_check(CAPTURE_OFFSET, 5'h01, 8'h01, 1'b1, 8'h00);
    drive(5'h00);
    check(cap, 8'h00);
    exp = 8'h00;
    for (int i = 0; i < 5; i++) begin
      drive(src | 5'(1 << i));
      exp = exp | 8'(1 << i);
      check(cap, exp);
    end
    rd_check(CAPTURE_OFFSET, 5'h1F, 8'h1F, 1'b1, 8'h00);
    @(negedge i_ref_clk);
    rise_en = 5'h00;
    fall_en = 5'h1F;
    drive(5'h1E);
    check(cap, 8'h01);
    rd_check(6'h13, 5'h1E, 8'h00, 1'b0, 8'h01);
    rd_check(CAPTURE_OFFSET, 5'h1C, 8'h03, 1'b1, 8'h00);
    @(negedge i_ref_clk);
    host    = 1'b0;
    rise_en = 5'h1F;
    drive(5'h1D);
    check(cap, 8'h00);
    @(negedge i_ref_clk);
    host = 1'b1;
    // each mode entry wipes a freshly set bit; suspend high only on the serial entry
    for (int m = 0; m < 3; m++) begin
      drive(src ^ 5'h10);
      check(cap, 8'h10);
      @(negedge i_ref_clk);
      mode = 3'(1 << m);
      susp = m[0];
      step();
      check(cap, 8'h00);
      @(negedge i_ref_clk);
      mode = 3'h0;
    end
    // second reset with the host connected: bit 0 must seed clear
    @(negedge i_ref_clk);
    i_reset_n = 1'b0;
    src       = 5'h0C;
    repeat (2) @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    step();
    check(cap, 8'h00);
    rd_check(CAPTURE_OFFSET, 5'h0D, 8'h01, 1'b1, 8'h00);
    step();
    final_report();
  end
endmodule
`default_nettype wire
